//--- osc_defines.vh
// constants for the optical module sideband controller
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH
// serial device address (arbitrary value)
`define OSC_DEV_ADDR 7'h50
`define OSC_MEM_DEPTH 8
`define OSC_PTR_W 3
// serial map offsets
`define OSC_OFS_STATUS 3'h0
`define OSC_OFS_LATCH 3'h1
// live status byte fields
`define OSC_ST_NOT_READY 0
`define OSC_ST_RX_LOST 1
`define OSC_ST_TX_OFF 2
`define OSC_ST_LOW_POWER 3
// latched event byte fields
`define OSC_LT_FAULT 0
`define OSC_LT_LOS 1
`define OSC_MEM_RESET 8'h00
`endif

//--- osc_sideband.v
// optical module sideband pins and two-wire serial slave
`timescale 1ns/1ps
`include "osc_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// R1: serial commands are answered only while the select pin is held low by the host.
// R2: the interrupt output is asserted while latched event details wait to be read over the serial link; here ones written to the latch byte, or R9, clear it.
// R3: the transmitter is switched off while the disable pin is high and allowed while it is low.
// R4: the module-absent output is tied low inside the module.
// R5: the not-ready output is asserted while an operational fault is present.
// R6: the receive-loss output is asserted while received optical power is below threshold.
// R7: while the power-down pin is high the module goes to its low-power state.
// R8: the serial interface keeps working in power-down.
// R9: a falling edge on the power-down pin resets the whole module, serial interface included.
// R10: the host drives the serial clock and each side drives the data line only in its own phases.
// R11: the host synchronises the status outputs before using them.
module osc_sideband #(
    parameter [6:0] DEV_ADDR = `OSC_DEV_ADDR,
    parameter MEM_DEPTH = `OSC_MEM_DEPTH
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // host control pins
    input wire mod_desel,
    input wire tx_dis,
    input wire power_down_rst,
    // two-wire serial link
    input wire two_wire_clock,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // internal conditions
    input wire fault_present,
    input wire rx_power_low,
    // status pins
    output reg interrupt_b,
    output reg module_absent,
    output reg module_not_ready,
    output reg receive_signal_lost,
    // internal controls
    output reg tx_enable,
    output reg low_power
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_AACK = 3'h2;
localparam [2:0] ST_WDAT = 3'h3;
localparam [2:0] ST_WACK = 3'h4;
localparam [2:0] ST_RDAT = 3'h5;
localparam [2:0] ST_RACK = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
reg [1:0] desel_sy;
reg [1:0] txdis_sy;
reg [1:0] pdown_sy;
reg [1:0] scl_sy;
reg [1:0] sda_sy;
reg scl_d;
reg sda_d;
reg pdown_d;

always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        desel_sy <= 2'h3;
        txdis_sy <= 2'h3;
        pdown_sy <= 2'h0;
        scl_sy <= 2'h3;
        sda_sy <= 2'h3;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        pdown_d <= 1'b0;
    end
    else
    begin
        desel_sy <= {desel_sy[0], mod_desel};
        txdis_sy <= {txdis_sy[0], tx_dis};
        pdown_sy <= {pdown_sy[0], power_down_rst};
        scl_sy <= {scl_sy[0], two_wire_clock};
        sda_sy <= {sda_sy[0], sda_in};
        scl_d <= scl_sy[1];
        sda_d <= sda_sy[1];
        pdown_d <= pdown_sy[1];
    end
end

wire scl_s = scl_sy[1];
wire sda_s = sda_sy[1];
wire selected = ~desel_sy[1];
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

////////////////////////////////////////////////////////////////////////////////
// reset from the power-down pin falling edge, same as a power cycle
reg soft_rst;

always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
        soft_rst <= 1'b0;
    else
        soft_rst <= pdown_d & ~pdown_sy[1]; // see R9
end

////////////////////////////////////////////////////////////////////////////////
// serial map state
reg [2:0] state;
reg [3:0] bitcnt;
reg [7:0] shreg;
reg [`OSC_PTR_W-1:0] ptr;
reg ptr_phase;
reg rw;
reg nack;
reg [1:0] latch;
reg [7:0] mem [0:MEM_DEPTH-1];
integer i;

function [7:0] rd_byte;
    input [`OSC_PTR_W-1:0] idx;
    begin
        case (idx)
            `OSC_OFS_STATUS:
            begin
                rd_byte = 8'h00;
                rd_byte[`OSC_ST_NOT_READY] = module_not_ready;
                rd_byte[`OSC_ST_RX_LOST] = receive_signal_lost;
                rd_byte[`OSC_ST_TX_OFF] = ~tx_enable;
                rd_byte[`OSC_ST_LOW_POWER] = low_power;
            end
            `OSC_OFS_LATCH: rd_byte = {6'h00, latch};
            default: rd_byte = mem[idx];
        endcase
    end
endfunction

wire byte_done = scl_fall & (bitcnt == 4'h8);
wire data_wr = (state == ST_WDAT) & byte_done & ~ptr_phase;
wire [7:0] next_byte = rd_byte(ptr);

////////////////////////////////////////////////////////////////////////////////
// two-wire slave; runs regardless of the power-down level
always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        state <= ST_IDLE;
        bitcnt <= 4'h0;
        shreg <= 8'h00;
        ptr <= {`OSC_PTR_W{1'b0}};
        ptr_phase <= 1'b0;
        rw <= 1'b0;
        nack <= 1'b0;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        for (i = 0; i < MEM_DEPTH; i = i + 1)
            mem[i] <= `OSC_MEM_RESET;
    end
    else if (soft_rst)
    begin
        state <= ST_IDLE; // see R9
        bitcnt <= 4'h0;
        shreg <= 8'h00;
        ptr <= {`OSC_PTR_W{1'b0}};
        ptr_phase <= 1'b0;
        rw <= 1'b0;
        nack <= 1'b0;
        sda_oe <= 1'b0;
        for (i = 0; i < MEM_DEPTH; i = i + 1)
            mem[i] <= `OSC_MEM_RESET;
    end
    else if (!selected)
    begin
        // deselect mid-transfer drops the line at once
        state <= ST_IDLE; // see R1
        sda_oe <= 1'b0;
    end
    else if (start_cond) // see R8
    begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        ptr_phase <= 1'b1;
        sda_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
    end
    else
    begin
        case (state)
            ST_ADDR, ST_WDAT:
            begin
                if (scl_rise)
                begin
                    shreg <= {shreg[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end
                else if (byte_done)
                begin
                    if (state == ST_ADDR)
                    begin
                        if (shreg[7:1] == DEV_ADDR)
                        begin
                            state <= ST_AACK;
                            rw <= shreg[0];
                            sda_oe <= 1'b1; // see R10
                        end
                        else
                            state <= ST_IDLE;
                    end
                    else
                    begin
                        state <= ST_WACK;
                        sda_oe <= 1'b1; // see R10
                        ptr_phase <= 1'b0;
                        if (ptr_phase)
                            ptr <= shreg[`OSC_PTR_W-1:0];
                        else
                        begin
                            // the two live offsets are not stored
                            if (ptr != `OSC_OFS_STATUS && ptr != `OSC_OFS_LATCH)
                                mem[ptr] <= shreg;
                            ptr <= ptr + 1'b1;
                        end
                    end
                end
            end
            ST_AACK:
            begin
                if (scl_fall)
                begin
                    bitcnt <= rw ? 4'h1 : 4'h0;
                    if (rw)
                    begin
                        state <= ST_RDAT;
                        shreg <= next_byte;
                        sda_oe <= ~next_byte[7]; // see R10
                        ptr <= ptr + 1'b1;
                    end
                    else
                    begin
                        state <= ST_WDAT;
                        sda_oe <= 1'b0;
                    end
                end
            end
            ST_WACK:
            begin
                if (scl_fall)
                begin
                    state <= ST_WDAT;
                    bitcnt <= 4'h0;
                    sda_oe <= 1'b0; // see R10
                end
            end
            ST_RDAT:
            begin
                if (byte_done)
                begin
                    state <= ST_RACK;
                    sda_oe <= 1'b0; // see R10
                end
                else if (scl_fall)
                begin
                    sda_oe <= ~shreg[6];
                    shreg <= {shreg[6:0], 1'b0};
                    bitcnt <= bitcnt + 4'h1;
                end
            end
            ST_RACK:
            begin
                if (scl_rise)
                    nack <= sda_s;
                else if (scl_fall)
                begin
                    if (nack)
                        state <= ST_IDLE;
                    else
                    begin
                        state <= ST_RDAT;
                        shreg <= next_byte;
                        sda_oe <= ~next_byte[7];
                        bitcnt <= 4'h1;
                        ptr <= ptr + 1'b1;
                    end
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// event latch and status pins
// a new event in the clearing cycle survives: set wins over clear
wire [1:0] lt_set = {rx_power_low, fault_present};
wire [1:0] lt_clr = data_wr && (ptr == `OSC_OFS_LATCH) ? shreg[1:0] : 2'h0;
wire [1:0] next_latch = (latch & ~lt_clr) | lt_set;

always @(posedge sys_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        latch <= 2'h0;
        interrupt_b <= 1'b1;
        module_absent <= 1'b0;
        module_not_ready <= 1'b0;
        receive_signal_lost <= 1'b0;
        tx_enable <= 1'b0;
        low_power <= 1'b0;
    end
    else if (soft_rst)
    begin
        latch <= 2'h0;
        interrupt_b <= 1'b1;
        module_not_ready <= 1'b0;
        receive_signal_lost <= 1'b0;
        tx_enable <= 1'b0;
        low_power <= pdown_sy[1];
    end
    else
    begin
        latch <= next_latch;
        interrupt_b <= ~(|next_latch); // see R2
        module_absent <= 1'b0; // see R4
        module_not_ready <= fault_present; // see R5
        receive_signal_lost <= rx_power_low; // see R6
        tx_enable <= ~txdis_sy[1]; // see R3
        low_power <= pdown_sy[1]; // see R7
    end
end

endmodule

//--- osc_sideband_properties.sv
// port checks for the optical module sideband controller
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module osc_sideband_properties (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // host side
    input wire mod_desel,
    input wire tx_dis,
    input wire power_down_rst,
    input wire two_wire_clock,
    input wire sda_oe,
    // conditions and outputs
    input wire fault_present,
    input wire rx_power_low,
    input wire interrupt_b,
    input wire module_absent,
    input wire module_not_ready,
    input wire receive_signal_lost,
    input wire tx_enable,
    input wire low_power
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // four cycles cover the input synchroniser plus the output register
    sequence s_desel;
        mod_desel[*4];
    endsequence
    sequence s_scl_high;
        two_wire_clock[*4];
    endsequence
    a_absent_tied: assert property (!module_absent)
        else $error("module absent driven high");
    a_tx_off: assert property (tx_dis |-> ##3 !tx_enable)
        else $error("transmitter left on while disabled");
    a_not_ready: assert property (fault_present |=> module_not_ready)
        else $error("not ready missing during fault");
    a_los_clear: assert property (!rx_power_low |=> !receive_signal_lost)
        else $error("signal lost without low power");
    a_low_power: assert property (power_down_rst[*3] |=> low_power)
        else $error("low power state not entered");
    a_int_raise: assert property (fault_present |-> ##[1:3] !interrupt_b)
        else $error("interrupt not raised on fault");
    a_desel_quiet: assert property (s_desel |-> !sda_oe)
        else $error("data wire driven while deselected");
    a_phase_hold: assert property (s_scl_high |-> $stable(sda_oe))
        else $error("data wire changed while clock high");
endmodule
bind osc_sideband osc_sideband_properties i_props (.sys_clk(sys_clk), .rst_b(rst_b), .mod_desel(mod_desel),
    .tx_dis(tx_dis), .power_down_rst(power_down_rst), .two_wire_clock(two_wire_clock), .sda_oe(sda_oe),
    .fault_present(fault_present), .rx_power_low(rx_power_low), .interrupt_b(interrupt_b),
    .module_absent(module_absent), .module_not_ready(module_not_ready),
    .receive_signal_lost(receive_signal_lost), .tx_enable(tx_enable), .low_power(low_power));

//--- osc_host.sv
// host board model driving the two-wire link
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module osc_host (
    // two-wire link
    output reg two_wire_clock,
    output reg host_pull,
    input wire sda
);
    initial
    begin
        two_wire_clock = 1'b1;
        host_pull = 1'b0;
    end
    // works from idle and as a repeated start after an acknowledge
    task frame_start;
    begin
        #50 host_pull = 1'b0;
        #50 two_wire_clock = 1'b1;
        #100 host_pull = 1'b1;
        #100 two_wire_clock = 1'b0;
    end
    endtask
    // nine clocks, msb first; a 1 bit releases the wire so the module can answer
    task xfer(input [8:0] d, output [8:0] q);
        integer i;
    begin
        for (i = 8; i >= 0; i = i - 1)
        begin
            #50 host_pull = ~d[i];
            #50 two_wire_clock = 1'b1;
            #90 q[i] = sda;
            #10 two_wire_clock = 1'b0;
        end
    end
    endtask
    task frame_stop;
    begin
        #50 host_pull = 1'b1;
        #50 two_wire_clock = 1'b1;
        #100 host_pull = 1'b0;
    end
    endtask
endmodule

//--- testbench.sv
// self-checking bench for the optical module sideband controller
`timescale 1ns/1ps
`include "osc_defines.vh"
`define CHK(nm, e, a) \
    comparisons = comparisons + 1; \
    if ((a) !== (e)) \
    begin \
        $display("CHECK FAILED %s expected %h seen %h", nm, e, a); \
        n_errors = n_errors + 1; \
    end
////////////////////////////////////////////////////////////////////////////////
module testbench;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg mod_desel = 1'b0;
    reg tx_dis = 1'b1;
    reg pd = 1'b0;
    reg fault = 1'b0;
    reg rx_low = 1'b0;
    wire scl, host_pull, sda_out, sda_oe, int_b, absent, not_ready, los, tx_en, low_pwr;
    // open drain wire with pull-up
    wire sda = ~(host_pull | (sda_oe & ~sda_out));
    integer n_errors = 0;
    integer comparisons = 0;
    reg [8:0] q;
    // the host samples the open-drain interrupt through two flops
    reg [1:0] int_sync = 2'h3;
    always @(posedge sys_clk)
    begin
        int_sync <= {int_sync[0], int_b};
    end
    osc_sideband i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .mod_desel(mod_desel), .tx_dis(tx_dis),
        .power_down_rst(pd), .two_wire_clock(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .fault_present(fault), .rx_power_low(rx_low), .interrupt_b(int_b), .module_absent(absent),
        .module_not_ready(not_ready), .receive_signal_lost(los), .tx_enable(tx_en), .low_power(low_pwr));
    osc_host i_host (.two_wire_clock(scl), .host_pull(host_pull), .sda(sda));
    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task close_out;
    begin
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    initial
    begin
        #1000000;
        n_errors = n_errors + 1;
        close_out;
    end
    task step(input integer n);
    begin
        repeat (n) @(posedge sys_clk);
        #2;
    end
    endtask
    task send(input [7:0] d, input ack);
    begin
        i_host.xfer({d, 1'b1}, q);
        `CHK("ack", ack, ~q[0])
    end
    endtask
    task wr(input [7:0] ptr, input [15:0] d, input ack);
    begin
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b0}, ack);
        send(ptr, ack);
        send(d[15:8], ack);
        send(d[7:0], ack);
        i_host.frame_stop;
        step(4);
    end
    endtask
    task rd(input [7:0] ptr, input [7:0] exp);
    begin
        wr(ptr, 16'h0000, 1'b1);
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b0}, 1'b1);
        send(ptr, 1'b1);
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b1}, 1'b1);
        i_host.xfer(9'h1FF, q);
        i_host.frame_stop;
        step(4);
        `CHK("read", exp, q[8:1])
    end
    endtask
    task t_pins;
    begin
        `CHK("absent", 1'b0, absent)
        `CHK("tx off", 1'b0, tx_en)
        `CHK("int idle", 1'b1, int_b)
        tx_dis = 1'b0;
        step(4);
        `CHK("tx on", 1'b1, tx_en)
        fault = 1'b1;
        rx_low = 1'b1;
        step(1);
        `CHK("not ready", 1'b1, not_ready)
        `CHK("los", 1'b1, los)
        fault = 1'b0;
        rx_low = 1'b0;
        step(2);
        `CHK("int", 1'b0, int_b)
        `CHK("int synced", 1'b0, int_sync[1])
        rd({5'h00, `OSC_OFS_LATCH}, 8'h03);
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b0}, 1'b1);
        send({5'h00, `OSC_OFS_LATCH}, 1'b1);
        send(8'h03, 1'b1);
        i_host.frame_stop;
        step(4);
        `CHK("int clear", 1'b1, int_b)
    end
    endtask
    task t_mem;
    begin
        mod_desel = 1'b1;
        step(4);
        wr(8'h04, 16'h7777, 1'b0);
        mod_desel = 1'b0;
        step(4);
        // a foreign address must not be acknowledged
        i_host.frame_start;
        send({`OSC_DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        i_host.frame_stop;
        step(4);
        wr(8'h02, 16'hA53C, 1'b1);
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b0}, 1'b1);
        send(8'h02, 1'b1);
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b1}, 1'b1);
        i_host.xfer(9'h1FE, q);
        `CHK("first", 8'hA5, q[8:1])
        i_host.xfer(9'h1FF, q);
        `CHK("second", 8'h3C, q[8:1])
        i_host.frame_stop;
        step(4);
    end
    endtask
    task t_pd;
    begin
        pd = 1'b1;
        step(4);
        `CHK("low power", 1'b1, low_pwr)
        rd({5'h00, `OSC_OFS_STATUS}, 8'h08);
        // leave a latched event behind so the reset has something to clear
        fault = 1'b1;
        step(1);
        fault = 1'b0;
        pd = 1'b0;
        tx_dis = 1'b1;
        step(8);
        `CHK("power up", 1'b0, low_pwr)
        `CHK("int after reset", 1'b1, int_b)
        i_host.frame_start;
        send({`OSC_DEV_ADDR, 1'b1}, 1'b1);
        i_host.xfer(9'h1FE, q);
        `CHK("pointer cleared", 8'h04, q[8:1])
        i_host.xfer(9'h1FE, q);
        `CHK("latch cleared", 8'h00, q[8:1])
        i_host.xfer(9'h1FF, q);
        `CHK("memory cleared", 8'h00, q[8:1])
        i_host.frame_stop;
        step(4);
    end
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        step(6);
        t_pins;
        t_mem;
        t_pd;
        close_out;
    end
endmodule
